// ### hdl/lapwm_top.v
`timescale 1ns/100ps
`include "lapwm_map.vh"

// How it works
// - Watchdog fault latches until reset, highest priority, 5 percent duty.
// - Oscillator frequency fault, priority two, 10.625 percent duty.
// - Self-check fault latches until reset, priority three, 16.25 percent duty.
// - PLL unlock, priority four, 21.875 percent duty while unlocked.
// - Zero-crossing integrity fault, priority five, 27.5 percent while present.
// - Mean-calculation fault, priority six, 33.125 percent for one frame.
// - Unmasked supply-low sources, priority seven, 38.75 percent while any remains.
// - Weak field, priority eight, 44.375 percent until field recovers.
// - Corrected memory error, priority nine, 50 percent for one frame.
// - Signal clipping, priority ten, 55.625 percent while it lasts.
// - Strong field, priority eleven, 61.25 percent until field drops.
// - Temperature range, lowest priority, 66.875 percent until back in range.
// - Frame rate from band and fine fields, 3125 Hz down to 98 Hz.
// - 32 coefficients at 11.25 degree points, subtracted from the angle.
// - Coefficients are 12-bit two's complement values.
// - Scale select picks 22.5 or 45 degrees full-scale correction.
// - Between points the correction is linearly interpolated.
// - Latency is the same with correction on or off.
// - With correction off the datapath never reads the coefficients.
// - Angle 0 to 360 maps to 5 to 95 percent; rising edge fixed.
// - Fault output on: style clear floats pin, style set doubles period.
module lapwm_top (
  input wire MCLK,
  input wire RESET,
  input wire [11:0] ANGLE_IN,
  input wire LIN_ENABLE,
  input wire CORRECTION_SCALE_SEL,
  input wire COEF_WR,
  input wire [4:0] COEF_ADDR,
  input wire [11:0] COEF_DATA,
  input wire [2:0] PWM_BAND,
  input wire [3:0] PWM_FREQ,
  input wire ERR_TO_OUT,
  input wire ERR_STYLE,
  input wire WATCHDOG_FAULT,
  input wire OSC_FREQ_FAULT,
  input wire SELF_CHECK_FAULT,
  input wire PLL_LOCK_FAULT,
  input wire ZERO_CROSS_INTEGRITY_FAULT,
  input wire MEAN_CALC_FAULT,
  input wire SUPPLY_LOW_A,
  input wire SUPPLY_LOW_CC,
  input wire SUPPLY_LOW_A_MASK,
  input wire SUPPLY_LOW_CC_MASK,
  input wire WEAK_FIELD_FAULT,
  input wire NVM_CORRECTED_FAULT,
  input wire ADC_CLIP_FAULT,
  input wire STRONG_FIELD_FAULT,
  input wire TEMPERATURE_RANGE_FAULT,
  output reg [11:0] CORRECTED_ANGLE,
  output reg [3:0] ACTIVE_FAULT,
  output reg PWM_OUT,
  output reg PWM_OE
);

  // ==========================================================
  // Correction coefficient storage
  // ==========================================================
  reg [11:0] coef [0:`LAPWM_COEF_N-1];

  genvar gi;
  generate
    for (gi = 0; gi < `LAPWM_COEF_N; gi = gi + 1) begin : g_coef
      always @(posedge MCLK) begin
        if (RESET) begin
          coef[gi] <= 12'h000;
        end else if (COEF_WR && (COEF_ADDR == gi)) begin
          coef[gi] <= COEF_DATA;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Interpolation, stage one
  // ==========================================================
  // Top five bits select the 11.25 degree segment, low seven the position in it
  wire [4:0] seg = ANGLE_IN[11:7];
  wire [6:0] frac = ANGLE_IN[6:0];
  wire [4:0] seg_next = seg + 5'h01;

  // Table reads are gated so that a disabled path ignores table contents
  wire [11:0] c_lo = LIN_ENABLE ? coef[seg] : 12'h000;
  wire [11:0] c_hi = LIN_ENABLE ? coef[seg_next] : 12'h000;

  wire signed [12:0] c_diff = $signed({c_hi[11], c_hi}) - $signed({c_lo[11], c_lo});
  wire signed [20:0] c_step = c_diff * $signed({1'b0, frac});
  wire signed [20:0] c_base = $signed({{2{c_lo[11]}}, c_lo, 7'h00});
  wire signed [20:0] next_interp = c_base + c_step;

  reg [11:0] angle_d1;
  reg signed [20:0] interp_d1;
  reg lin_en_d1;
  reg scale_d1;

  always @(posedge MCLK) begin
    if (RESET) begin
      angle_d1 <= 12'h000;
      interp_d1 <= 21'sh00_0000;
      lin_en_d1 <= 1'b0;
      scale_d1 <= 1'b0;
    end else begin
      angle_d1 <= ANGLE_IN;
      interp_d1 <= next_interp;
      lin_en_d1 <= LIN_ENABLE;
      scale_d1 <= CORRECTION_SCALE_SEL;
    end
  end

  // ==========================================================
  // Subtraction, stage two
  // ==========================================================
  // Arithmetic shift truncates toward minus infinity; sub-LSB error is accepted
  wire signed [20:0] corr_narrow = interp_d1 >>> `LAPWM_SHIFT_NARROW;
  wire signed [20:0] corr_wide = interp_d1 >>> `LAPWM_SHIFT_WIDE;
  wire [11:0] corr = scale_d1 ? corr_wide[11:0] : corr_narrow[11:0];
  // Modulo 4096 wrap keeps the result inside one revolution
  wire [11:0] next_corrected = angle_d1 - corr;

  always @(posedge MCLK) begin
    if (RESET) begin
      CORRECTED_ANGLE <= 12'h000;
    end else begin
      // Both settings pass through the same two registers
      CORRECTED_ANGLE <= lin_en_d1 ? next_corrected : angle_d1;
    end
  end

  // ==========================================================
  // Fault capture
  // ==========================================================
  reg watchdog_hold;
  reg self_check_hold;
  reg mean_pend;
  reg nvm_pend;
  reg frame_start;
  reg [3:0] frame_code;

  // One-shot faults are consumed when a frame starts with them selected
  wire mean_taken = frame_start && (frame_code == `LAPWM_F_MEAN);
  wire nvm_taken = frame_start && (frame_code == `LAPWM_F_NVM);

  always @(posedge MCLK) begin
    if (RESET) begin
      watchdog_hold <= 1'b0;
      self_check_hold <= 1'b0;
      mean_pend <= 1'b0;
      nvm_pend <= 1'b0;
    end else begin
      if (WATCHDOG_FAULT) begin
        watchdog_hold <= 1'b1;
      end
      if (SELF_CHECK_FAULT) begin
        self_check_hold <= 1'b1;
      end
      // A new event in the clearing cycle keeps the flag set
      if (MEAN_CALC_FAULT) begin
        mean_pend <= 1'b1;
      end else if (mean_taken) begin
        mean_pend <= 1'b0;
      end
      if (NVM_CORRECTED_FAULT) begin
        nvm_pend <= 1'b1;
      end else if (nvm_taken) begin
        nvm_pend <= 1'b0;
      end
    end
  end

  wire supply_low = (SUPPLY_LOW_A && !SUPPLY_LOW_A_MASK) || (SUPPLY_LOW_CC && !SUPPLY_LOW_CC_MASK);

  // Bit k-1 holds fault of priority k; raw event is ORed in so the code follows one cycle after it
  wire [11:0] fault_vec = {
    TEMPERATURE_RANGE_FAULT,
    STRONG_FIELD_FAULT,
    ADC_CLIP_FAULT,
    nvm_pend || NVM_CORRECTED_FAULT,
    WEAK_FIELD_FAULT,
    supply_low,
    mean_pend || MEAN_CALC_FAULT,
    ZERO_CROSS_INTEGRITY_FAULT,
    PLL_LOCK_FAULT,
    self_check_hold || SELF_CHECK_FAULT,
    OSC_FREQ_FAULT,
    watchdog_hold || WATCHDOG_FAULT
  };

  reg [3:0] next_code;
  integer k;

  // Scan from lowest to highest priority so the highest one is left standing
  always @* begin
    next_code = `LAPWM_F_NONE;
    for (k = `LAPWM_F_COUNT; k >= 1; k = k - 1) begin
      if (fault_vec[k-1]) begin
        next_code = k[3:0];
      end
    end
  end

  // ==========================================================
  // Frame period
  // ==========================================================
  // Counts are integers; the longest doubled frame still fits in 18 bits
  localparam [31:0] BASE_CYC_W = `LAPWM_BASE_CYC;
  localparam [31:0] BAND_STEP_W = `LAPWM_BAND_STEP_CYC;
  localparam [31:0] FINE_STEP_W = `LAPWM_FINE_STEP_CYC;
  wire [17:0] base_cyc = BASE_CYC_W[17:0];
  wire [17:0] band_step = BAND_STEP_W[17:0];
  wire [17:0] fine_step = FINE_STEP_W[17:0];
  wire [17:0] band_part = band_step << PWM_BAND;
  wire [17:0] fine_part = (fine_step << PWM_BAND) * {14'h0000, PWM_FREQ};
  wire [17:0] next_period = base_cyc + band_part + fine_part;

  // ==========================================================
  // Duty selection
  // ==========================================================
  wire [15:0] duty_angle = `LAPWM_DUTY_MIN + `LAPWM_DUTY_PER_LSB * {4'h0, CORRECTED_ANGLE};
  wire [15:0] duty_fault = `LAPWM_DUTY_MIN + `LAPWM_DUTY_FAULT_STEP * {12'h000, next_code - 4'h1};
  wire report = ERR_TO_OUT && (next_code != `LAPWM_F_NONE);

  reg [17:0] cnt;
  reg [17:0] period_l;
  reg [15:0] duty_l;
  reg float_l;

  wire frame_end = (cnt == period_l - 18'h0_0001);

  always @(posedge MCLK) begin
    if (RESET) begin
      cnt <= 18'h0_0000;
      period_l <= 18'h0_0001;
      duty_l <= 16'h0000;
      float_l <= 1'b0;
      frame_start <= 1'b0;
      frame_code <= `LAPWM_F_NONE;
    end else begin
      frame_start <= frame_end;
      if (frame_end) begin
        // Settings are taken only at frame boundaries, so rising edges stay periodic
        cnt <= 18'h0_0000;
        frame_code <= next_code;
        if (report && ERR_STYLE) begin
          period_l <= {next_period[16:0], 1'b0};
          duty_l <= duty_fault;
          float_l <= 1'b0;
        end else if (report) begin
          period_l <= next_period;
          duty_l <= duty_angle;
          float_l <= 1'b1;
        end else begin
          period_l <= next_period;
          duty_l <= duty_angle;
          float_l <= 1'b0;
        end
      end else begin
        cnt <= cnt + 18'h0_0001;
      end
    end
  end

  // ==========================================================
  // Output stage
  // ==========================================================
  // Compare cnt/period against duty/40960 without a divider
  wire [35:0] lhs = {18'h0_0000, cnt} * `LAPWM_DUTY_DEN;
  wire [35:0] rhs = {18'h0_0000, period_l} * {20'h0_0000, duty_l};

  always @(posedge MCLK) begin
    if (RESET) begin
      PWM_OUT <= 1'b0;
      PWM_OE <= 1'b0;
      ACTIVE_FAULT <= `LAPWM_F_NONE;
    end else begin
      PWM_OUT <= (lhs < rhs) && !float_l;
      PWM_OE <= !float_l;
      ACTIVE_FAULT <= next_code;
    end
  end

endmodule

// ### hdl/lapwm_map.vh
`ifndef LAPWM_MAP_VH
`define LAPWM_MAP_VH

// ==========================================================
// Clock and frame timing
// ==========================================================
`define LAPWM_CLK_HZ 10000000
// Frame period = base + band_step * 2^band + fine_step * 2^band * fine
`define LAPWM_BASE_NS 280000
`define LAPWM_BAND_STEP_NS 40000
`define LAPWM_FINE_STEP_NS 2500
`define LAPWM_NS_TO_CYC(ns) (((ns) * (`LAPWM_CLK_HZ / 1000000)) / 1000)
`define LAPWM_BASE_CYC `LAPWM_NS_TO_CYC(`LAPWM_BASE_NS)
`define LAPWM_BAND_STEP_CYC `LAPWM_NS_TO_CYC(`LAPWM_BAND_STEP_NS)
`define LAPWM_FINE_STEP_CYC `LAPWM_NS_TO_CYC(`LAPWM_FINE_STEP_NS)

// ==========================================================
// Duty cycle, in units of 1/40960 of the frame
// ==========================================================
`define LAPWM_DUTY_DEN 40960
// 5 percent floor of the angle range
`define LAPWM_DUTY_MIN 16'h0800
// 90 percent span over 4096 angle codes gives 9 units per code
`define LAPWM_DUTY_PER_LSB 16'h0009
// Fault code k sits at 5 + 5.625 * (k - 1) percent
`define LAPWM_DUTY_FAULT_STEP 16'h0900

// ==========================================================
// Fault priority codes, 1 is highest, 0 is none
// ==========================================================
`define LAPWM_F_NONE 4'h0
`define LAPWM_F_WATCHDOG 4'h1
`define LAPWM_F_OSC 4'h2
`define LAPWM_F_SELFCHK 4'h3
`define LAPWM_F_PLL 4'h4
`define LAPWM_F_ZCROSS 4'h5
`define LAPWM_F_MEAN 4'h6
`define LAPWM_F_SUPPLY 4'h7
`define LAPWM_F_WEAK 4'h8
`define LAPWM_F_NVM 4'h9
`define LAPWM_F_CLIP 4'hA
`define LAPWM_F_STRONG 4'hB
`define LAPWM_F_TEMP 4'hC
`define LAPWM_F_COUNT 12

// ==========================================================
// Correction table
// ==========================================================
`define LAPWM_COEF_N 32
// Coefficient LSB to angle LSB: 1/8 with scale clear, 1/4 with it set,
// plus 7 bits of interpolation fraction
`define LAPWM_SHIFT_NARROW 10
`define LAPWM_SHIFT_WIDE 9

`endif

// ### sim/lapwm_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Port checks
module lapwm_chk (
  input wire MCLK,
  input wire RESET,
  input wire [11:0] ANGLE_IN,
  input wire LIN_ENABLE,
  input wire WATCHDOG_FAULT,
  input wire OSC_FREQ_FAULT,
  input wire SUPPLY_LOW_CC,
  input wire SUPPLY_LOW_CC_MASK,
  input wire ADC_CLIP_FAULT,
  input wire TEMPERATURE_RANGE_FAULT,
  input wire [11:0] CORRECTED_ANGLE,
  input wire [3:0] ACTIVE_FAULT,
  input wire PWM_OUT,
  input wire PWM_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  wd_latch_a: assert property (ACTIVE_FAULT == 4'h1 |=> ACTIVE_FAULT == 4'h1) else $error("watchdog code dropped");
  wd_code_a: assert property (WATCHDOG_FAULT |=> ACTIVE_FAULT == 4'h1) else $error("watchdog code missing");
  osc_prio_a: assert property (OSC_FREQ_FAULT |=> ACTIVE_FAULT inside {4'h1, 4'h2}) else $error("osc code wrong");
  supply_mask_a: assert property (SUPPLY_LOW_CC && !SUPPLY_LOW_CC_MASK |=> ACTIVE_FAULT inside {[4'h1:4'h7]})
    else $error("supply code wrong");
  clip_prio_a: assert property (ADC_CLIP_FAULT |=> ACTIVE_FAULT inside {[4'h1:4'hA]}) else $error("clip code wrong");
  temp_seen_a: assert property (TEMPERATURE_RANGE_FAULT |=> ACTIVE_FAULT != 4'h0) else $error("temp code missing");
  lat_off_a: assert property (!LIN_ENABLE |-> ##2 CORRECTED_ANGLE == $past(ANGLE_IN, 2))
    else $error("uncorrected angle wrong");
  float_low_a: assert property (!PWM_OE |-> !PWM_OUT) else $error("floated pin not low");
  rst_quiet_a: assert property ($fell(RESET) |-> !PWM_OE && !PWM_OUT && ACTIVE_FAULT == 4'h0)
    else $error("outputs active after reset");
  pulse_min_a: assert property ($rose(PWM_OUT) |=> PWM_OUT [*8]) else $error("pulse below floor");
endmodule

bind lapwm_top lapwm_chk u_chk (.MCLK, .RESET, .ANGLE_IN, .LIN_ENABLE, .WATCHDOG_FAULT, .OSC_FREQ_FAULT,
  .SUPPLY_LOW_CC, .SUPPLY_LOW_CC_MASK, .ADC_CLIP_FAULT, .TEMPERATURE_RANGE_FAULT, .CORRECTED_ANGLE,
  .ACTIVE_FAULT, .PWM_OUT, .PWM_OE);

// ### sim/lapwm_host.sv
`timescale 1ns/100ps
// ==========================================
// Host timer: high time and period per frame
module lapwm_host (
  input wire clk,
  input wire pwm,
  input wire oe,
  output int hi,
  output int per,
  output int frames
);
  // Released pin is pulled up, so a floated frame shows no rising edge
  wire pin = oe ? pwm : 1'b1;
  logic last = 1'b1;
  int h = 0;
  int p = 0;
  initial begin
    hi = 0;
    per = 0;
    frames = 0;
  end
  always @(posedge clk) begin
    last <= pin;
    if (pin && !last) begin
      hi <= h;
      per <= p;
      frames <= frames + 1;
      h <= 1;
      p <= 1;
    end else begin
      h <= h + int'(pin);
      p <= p + 1;
    end
  end
endmodule

// ### sim/lapwm_test.sv
`timescale 1ns/100ps
module lapwm_test;
  logic clk = 0, rst = 1, lin = 0, scl = 0, wr = 0, eto = 0, est = 0, cc = 0, ccm = 1, am = 0;
  logic [11:0] ang = 0, cdat = 0;
  logic [4:0] cadr = 0;
  logic [2:0] band = 0;
  logic [3:0] fine = 0;
  logic [12:1] flt = 0;
  wire [11:0] cang;
  wire [3:0] afl;
  wire pout, poe;
  int hi, per, frames, c[32], errors = 0, compares = 0;
  lapwm_top dut (.MCLK(clk), .RESET(rst), .ANGLE_IN(ang), .LIN_ENABLE(lin), .CORRECTION_SCALE_SEL(scl),
    .COEF_WR(wr), .COEF_ADDR(cadr), .COEF_DATA(cdat), .PWM_BAND(band), .PWM_FREQ(fine), .ERR_TO_OUT(eto),
    .ERR_STYLE(est), .WATCHDOG_FAULT(flt[1]), .OSC_FREQ_FAULT(flt[2]), .SELF_CHECK_FAULT(flt[3]),
    .PLL_LOCK_FAULT(flt[4]), .ZERO_CROSS_INTEGRITY_FAULT(flt[5]), .MEAN_CALC_FAULT(flt[6]),
    .SUPPLY_LOW_A(flt[7]), .SUPPLY_LOW_CC(cc), .SUPPLY_LOW_A_MASK(am), .SUPPLY_LOW_CC_MASK(ccm),
    .WEAK_FIELD_FAULT(flt[8]), .NVM_CORRECTED_FAULT(flt[9]), .ADC_CLIP_FAULT(flt[10]),
    .STRONG_FIELD_FAULT(flt[11]), .TEMPERATURE_RANGE_FAULT(flt[12]), .CORRECTED_ANGLE(cang),
    .ACTIVE_FAULT(afl), .PWM_OUT(pout), .PWM_OE(poe));
  lapwm_host host (.clk(clk), .pwm(pout), .oe(poe), .hi(hi), .per(per), .frames(frames));
  initial forever #50 clk = ~clk;
  // ==========================================
  // Helpers
  task cmp(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, e, s);
    end
  endtask
  task finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wait_frames(int n);
    int f0, i;
    f0 = frames;
    for (i = 0; i < n * 8000 && frames < f0 + n; i++) @(negedge clk);
    if (frames < f0 + n) begin
      errors++;
      finish_test;
    end
  endtask
  // Reference model kept apart from the design: floor interpolation, wrap at 32
  function int exp_ang(int a, bit s);
    int k, f;
    k = a >> 7;
    f = a & 127;
    return (a - ((c[k] * 128 + (c[(k + 1) % 32] - c[k]) * f) >>> (s ? 9 : 10))) & 4095;
  endfunction
  function int hi_of(int p, int d);
    return (p * d + 40959) / 40960;
  endfunction
  task put_coef(int k, int v);
    @(negedge clk) wr = 1;
    cadr = k[4:0];
    cdat = v[11:0];
    c[k] = v;
    @(negedge clk) wr = 0;
  endtask
  task chk_ang(int a, bit on, bit s);
    @(negedge clk) ang = a[11:0];
    lin = on;
    scl = s;
    repeat (2) @(negedge clk);
    cmp("angle", on ? exp_ang(a, s) : a, cang);
  endtask
  // ==========================================
  // Scenarios
  task test_lin;
    put_coef(0, 16);
    put_coef(1, -16);
    put_coef(31, -2048);
    chk_ang(0, 1, 0);
    chk_ang(0, 1, 1);
    chk_ang(12'h040, 1, 0);
    chk_ang(12'hFC0, 1, 0);
    chk_ang(12'hFC0, 0, 0);
    chk_ang(12'h7FF, 1, 1);
  endtask
  task test_duty;
    @(negedge clk) ang = 12'hFFF;
    lin = 0;
    wait_frames(3);
    cmp("period", 3200, per);
    cmp("high", hi_of(3200, 2048 + 9 * 4095), hi);
    @(negedge clk) ang = 0;
    band = 1;
    fine = 1;
    wait_frames(3);
    cmp("period", 3650, per);
    cmp("high", hi_of(3650, 2048), hi);
    @(negedge clk) band = 0;
    fine = 0;
  endtask
  task test_faults;
    @(negedge clk) cc = 1;
    repeat (2) @(negedge clk);
    cmp("fault", 0, afl);
    ccm = 0;
    repeat (2) @(negedge clk);
    cmp("fault", 7, afl);
    cc = 0;
    for (int k = 12; k >= 2; k--) begin
      if (k == 3) continue;
      @(negedge clk) flt[k] = 1;
      @(negedge clk);
      cmp("fault", k, afl);
    end
    @(negedge clk) flt = 0;
    @(negedge clk);
    cmp("fault", 6, afl);
    wait_frames(3);
    cmp("fault", 0, afl);
  endtask
  task test_style;
    @(negedge clk) eto = 1;
    est = 1;
    flt[12] = 1;
    wait_frames(3);
    cmp("period", 6400, per);
    cmp("high", hi_of(6400, 2048 + 2304 * 11), hi);
    est = 0;
    for (int i = 0; i < 8000 && poe !== 1'b0; i++) @(negedge clk);
    cmp("drive", 0, poe);
    @(negedge clk) flt[12] = 0;
    eto = 0;
  endtask
  task test_watchdog;
    @(negedge clk) flt[3] = 1;
    @(negedge clk) flt[3] = 0;
    repeat (2) @(negedge clk);
    cmp("fault", 3, afl);
    flt[1] = 1;
    @(negedge clk) flt[1] = 0;
    repeat (4) @(negedge clk);
    cmp("fault", 1, afl);
    eto = 1;
    est = 1;
    wait_frames(3);
    cmp("high", hi_of(6400, 2048), hi);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    test_lin;
    test_duty;
    test_faults;
    test_style;
    test_watchdog;
    finish_test;
  end
endmodule
